/* ppcs_consts.svh */
// timing, setpoint and width constants of the power-path charge sequencer
`ifndef PPCS_CONSTS_SVH
`define PPCS_CONSTS_SVH
`define PPCS_CLK_MHZ          100
`define PPCS_GOOD_DELAY_MS    500
`define PPCS_SWITCH_DELAY_MS  700
`define PPCS_HOLD_DELAY_MS    10
`define PPCS_DEGLITCH_MS      2
`define PPCS_DEAD_TIME_US     10
`define PPCS_SOFT_ON_US       20
`define PPCS_MS_CYC(ms)       ((ms) * 1000 * `PPCS_CLK_MHZ)
`define PPCS_US_CYC(us)       ((us) * `PPCS_CLK_MHZ)
`define PPCS_GOOD_CYC         `PPCS_MS_CYC(`PPCS_GOOD_DELAY_MS)
`define PPCS_SWITCH_CYC       `PPCS_MS_CYC(`PPCS_SWITCH_DELAY_MS)
`define PPCS_CHARGE_CYC       `PPCS_MS_CYC(`PPCS_SWITCH_DELAY_MS + `PPCS_HOLD_DELAY_MS)
`define PPCS_DEGLITCH_CYC     `PPCS_MS_CYC(`PPCS_DEGLITCH_MS)
`define PPCS_DEAD_CYC         `PPCS_US_CYC(`PPCS_DEAD_TIME_US)
`define PPCS_SOFT_CYC         `PPCS_US_CYC(`PPCS_SOFT_ON_US)
`define PPCS_DET_W            27
`define PPCS_DGL_W            18
`define PPCS_TMR_W            11
`define PPCS_CELLS_FLOAT      3'h2
`define PPCS_CELLS_GROUND     3'h3
`define PPCS_CELLS_REF        3'h4
`define PPCS_CELL_BASE_MV     16'hFA0
`define PPCS_CELL_DEFAULT_MV  16'h1068
`define PPCS_TRIM_SPAN_MV     16'h200
`define PPCS_TRIM_SHIFT       8
`endif

/* ppcs_pkg.sv */
// types shared by the power-path charge sequencer
`default_nettype none
`include "ppcs_consts.svh"
package ppcs_pkg;
    typedef enum logic [2:0] {
        SEL_PACK      = 3'b000,
        SEL_BREAK_IN  = 3'b001,
        SEL_ADAPTER   = 3'b010,
        SEL_WAIT_DROP = 3'b011,
        SEL_BREAK_OUT = 3'b100
    } ppcs_sel_e;
    typedef struct packed {
        logic rail_above_4v;
        logic detect_above_0v6;
        logic detect_above_2v4;
        logic rail_above_undervoltage_lockout;
        logic rail_above_pack_185mv;
        logic sense_low_near_pack;
        logic input_overvoltage;
        logic thermal_shutdown;
        logic thermistor_in_window;
        logic ratio_ref_above_2v4;
        logic pack_below_2v9;
        logic input_over_limit;
        logic input_power_limiting;
        logic cells_above_low;
        logic cells_above_high;
        logic trim_at_supply;
        logic charge_enable_n;
        logic learn;
    } ppcs_comp_s;
    typedef struct packed {
        logic bias_partial;
        logic bias_full;
        logic input_current_monitor;
        logic gate_drive_supply;
        logic adapter_valid_out;
        logic adapter_switch;
        logic pack_switch;
        logic adapter_gate_slow;
        logic pack_gate_slow;
        logic charge_enable;
        logic dpm_active;
    } ppcs_ctl_s;
    typedef struct packed {
        logic [2:0]  cell_count;
        logic [15:0] voltage_target_mv;
        logic [7:0]  charge_limit_code;
    } ppcs_set_s;
    typedef struct packed {
        ppcs_comp_s                s1;
        ppcs_comp_s                s2;
        ppcs_sel_e                 sel;
        logic [`PPCS_DET_W-1:0]    det_cnt;
        logic [`PPCS_DGL_W-1:0]    dgl_cnt;
        logic                      chg_req;
        logic                      learn_exit;
        logic [`PPCS_TMR_W-1:0]    dead_cnt;
        logic [`PPCS_TMR_W-1:0]    soft_cnt;
        ppcs_ctl_s                 ctl;
        ppcs_set_s                 set;
    } ppcs_state_s;
endpackage
`default_nettype wire

/* ppcs_sequencer.sv */
// power-path selection and charge-enable sequencing of the battery charger
`timescale 1ns/100ps
`default_nettype none
`include "ppcs_consts.svh"

module ppcs_sequencer
    import ppcs_pkg::*;
#(
    parameter int unsigned GOOD_CYC     = `PPCS_GOOD_CYC,
    parameter int unsigned SWITCH_CYC   = `PPCS_SWITCH_CYC,
    parameter int unsigned CHARGE_CYC   = `PPCS_CHARGE_CYC,
    parameter int unsigned DEGLITCH_CYC = `PPCS_DEGLITCH_CYC
)(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire ppcs_comp_s comp,
    input  wire logic [7:0] voltage_trim_code,
    input  wire logic [7:0] charge_current_code,
    output var  ppcs_ctl_s  ctl,
    output var  ppcs_set_s  setpoint
);
    localparam logic [`PPCS_TMR_W-1:0] DEAD_LAST = `PPCS_TMR_W'(`PPCS_DEAD_CYC - 1);
    localparam logic [`PPCS_TMR_W-1:0] SOFT_LOAD = `PPCS_TMR_W'(`PPCS_SOFT_CYC);

    ppcs_state_s r;
    ppcs_state_s next_r;
    logic        pwr_on;
    logic        full_on;
    logic        adp_ok;
    logic        t_good;
    logic        t_switch;
    logic        t_charge;
    logic        dgl_done;
    logic        dead_done;
    logic        learn_act;
    logic        switch_ok;
    logic [15:0] per_cell_mv;

    // cell-count decode of the two threshold comparators on the select pin
    function automatic logic [2:0] decode_cells(input logic above_low,
                                                input logic above_high);
        if (above_high)
            return `PPCS_CELLS_REF;
        else if (above_low)
            return `PPCS_CELLS_FLOAT;
        else
            return `PPCS_CELLS_GROUND;
    endfunction

    // levels derived from the synchronised comparators and the timers
    assign pwr_on    = r.s2.rail_above_4v;
    assign full_on   = pwr_on & r.s2.detect_above_0v6;
    assign adp_ok    = full_on & r.s2.detect_above_2v4;
    assign t_good    = r.det_cnt >= `PPCS_DET_W'(GOOD_CYC);
    assign t_switch  = r.det_cnt >= `PPCS_DET_W'(SWITCH_CYC);
    assign t_charge  = r.det_cnt >= `PPCS_DET_W'(CHARGE_CYC);
    assign dgl_done  = r.dgl_cnt >= `PPCS_DGL_W'(DEGLITCH_CYC);
    assign dead_done = r.dead_cnt >= DEAD_LAST;
    assign learn_act = adp_ok & r.s2.learn & ~r.learn_exit;
    assign switch_ok = adp_ok & t_switch & r.s2.rail_above_pack_185mv & ~learn_act;

    // per-cell target
    // product kept at 24 bits: code times span overflows 16 bits before the shift
    assign per_cell_mv = r.s2.trim_at_supply ? `PPCS_CELL_DEFAULT_MV :
        16'(24'(`PPCS_CELL_BASE_MV)
            + ((24'(voltage_trim_code) * 24'(`PPCS_TRIM_SPAN_MV)) >> `PPCS_TRIM_SHIFT));

    // next-state logic of the whole block
    always_comb
    begin
        next_r = r;
        next_r.s1 = comp;
        next_r.s2 = r.s1;

        if (!adp_ok)
            next_r.det_cnt = '0;
        else if (!t_charge)
            next_r.det_cnt = r.det_cnt + 1'b1;

        if (r.s2.charge_enable_n || !full_on)
        begin
            next_r.dgl_cnt = '0;
            next_r.chg_req = 1'b0;
        end
        else if (dgl_done)
            next_r.chg_req = 1'b1;
        else
            next_r.dgl_cnt = r.dgl_cnt + 1'b1;

        // auto exit of learn; set wins over clear
        if (learn_act && r.s2.pack_below_2v9)
            next_r.learn_exit = 1'b1;
        else if (!r.s2.learn)
            next_r.learn_exit = 1'b0;

        // selector state machine, break-before-make in both directions
        case (r.sel)
            SEL_PACK:
            begin
                if (switch_ok)
                    next_r.sel = SEL_BREAK_IN;
            end
            SEL_BREAK_IN:
            begin
                if (!switch_ok)
                    next_r.sel = SEL_BREAK_OUT;
                else if (dead_done)
                    next_r.sel = SEL_ADAPTER;
            end
            SEL_ADAPTER:
            begin
                if (learn_act)
                    next_r.sel = SEL_BREAK_OUT;
                else if (!adp_ok)
                    next_r.sel = SEL_WAIT_DROP;
            end
            SEL_WAIT_DROP:
            begin
                // wait for sense node near pack
                if (adp_ok)
                    next_r.sel = SEL_ADAPTER;
                else if (r.s2.sense_low_near_pack)
                    next_r.sel = SEL_BREAK_OUT;
            end
            SEL_BREAK_OUT:
            begin
                if (dead_done)
                    next_r.sel = SEL_PACK;
            end
            default:
                next_r.sel = SEL_PACK;
        endcase
        // no rail: selector parks at its power-up state
        if (!pwr_on)
            next_r.sel = SEL_PACK;

        // dead-time counter restarts on each state change
        if (next_r.sel != r.sel)
            next_r.dead_cnt = '0;
        else if (!dead_done)
            next_r.dead_cnt = r.dead_cnt + 1'b1;

        next_r.ctl.pack_switch    = pwr_on && (next_r.sel == SEL_PACK);
        // adapter drive only after the break state
        next_r.ctl.adapter_switch = pwr_on && (next_r.sel == SEL_ADAPTER
                                            || next_r.sel == SEL_WAIT_DROP);

        // slow turn-on window, turn-off is immediate
        if ((next_r.ctl.pack_switch && !r.ctl.pack_switch)
            || (next_r.ctl.adapter_switch && !r.ctl.adapter_switch))
            next_r.soft_cnt = SOFT_LOAD;
        else if (r.soft_cnt != '0)
            next_r.soft_cnt = r.soft_cnt - 1'b1;
        next_r.ctl.pack_gate_slow    = next_r.ctl.pack_switch && (next_r.soft_cnt != '0);
        next_r.ctl.adapter_gate_slow = next_r.ctl.adapter_switch && (next_r.soft_cnt != '0);

        next_r.ctl.bias_partial          = pwr_on && !full_on;
        // full bias, monitor and gated supply
        next_r.ctl.bias_full             = full_on;
        next_r.ctl.input_current_monitor = full_on;
        next_r.ctl.gate_drive_supply     = full_on && next_r.chg_req;
        // adapter valid after the good delay
        next_r.ctl.adapter_valid_out     = adp_ok && t_good;

        next_r.ctl.charge_enable = next_r.chg_req && adp_ok && t_charge
            && r.s2.rail_above_undervoltage_lockout && r.s2.rail_above_pack_185mv
            && !r.s2.input_overvoltage && !r.s2.thermal_shutdown
            && r.s2.thermistor_in_window && r.s2.ratio_ref_above_2v4
            && !r.s2.learn;

        // step the limit down while input current is over
        next_r.ctl.dpm_active = full_on && r.s2.input_power_limiting
                                && r.s2.input_over_limit;
        // otherwise track the ratio code, full scale is 100 mV sense
        if (next_r.ctl.dpm_active)
        begin
            if (r.set.charge_limit_code != 8'h00)
                next_r.set.charge_limit_code = r.set.charge_limit_code - 8'h01;
        end
        else if (r.set.charge_limit_code < charge_current_code)
            next_r.set.charge_limit_code = r.set.charge_limit_code + 8'h01;
        else
            next_r.set.charge_limit_code = charge_current_code;

        // cell count from the select pin
        next_r.set.cell_count = decode_cells(r.s2.cells_above_low, r.s2.cells_above_high);
        next_r.set.voltage_target_mv = 16'(per_cell_mv * 16'(r.set.cell_count));
    end

    // state register; reset leaves every switch and enable off
    always_ff @(posedge clock)
    begin
        if (srst)
            r <= '0;
        else
            r <= next_r;
    end

    assign ctl      = r.ctl;
    assign setpoint = r.set;

    // consecutive cycles with both selector switches off, for dead-time checks
    logic [`PPCS_TMR_W-1:0] off_run;
    always_ff @(posedge clock)
    begin
        if (srst)
            off_run <= '0;
        else if (r.ctl.adapter_switch || r.ctl.pack_switch)
            off_run <= '0;
        else if (off_run != '1)
            off_run <= off_run + 1'b1;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence leave_pack;
        r.sel == SEL_PACK ##1 r.sel == SEL_BREAK_IN;
    endsequence
    sequence leave_drop;
        r.sel == SEL_WAIT_DROP ##1 r.sel == SEL_BREAK_OUT;
    endsequence

    a_cells_decode: assert property (!$past(srst) |-> setpoint.cell_count inside
        {`PPCS_CELLS_FLOAT, `PPCS_CELLS_GROUND, `PPCS_CELLS_REF})
        else $error("cell count outside decode set");
    a_rail_disable: assert property (!pwr_on |=> ctl == '0)
        else $error("outputs active without input rail");
    // monitor held low in partial bias
    a_monitor_ground: assert property (pwr_on && !full_on |=>
        ctl.bias_partial && !ctl.input_current_monitor && !ctl.charge_enable)
        else $error("monitor active in partial bias");
    // gate supply only with enable low
    a_supply_gate: assert property (ctl.gate_drive_supply |->
        $past(!r.s2.charge_enable_n) && ctl.bias_full)
        else $error("gate supply without charge enable");
    // valid output waits the good delay
    a_valid_delay: assert property (ctl.adapter_valid_out |->
        $past(r.det_cnt) >= `PPCS_DET_W'(GOOD_CYC))
        else $error("adapter valid before delay");
    // charge waits for the full delay
    a_charge_delay: assert property (ctl.charge_enable |->
        $past(t_charge) && $past(r.s2.rail_above_pack_185mv) && r.chg_req)
        else $error("charge enabled too early");
    a_charge_block: assert property (r.s2.learn || r.s2.thermal_shutdown
        || !r.s2.ratio_ref_above_2v4 |=> !ctl.charge_enable)
        else $error("charge enabled while blocked");
    a_break_make: assert property (!(ctl.adapter_switch && ctl.pack_switch))
        else $error("adapter and pack switch both on");
    // hand-over only after delay and margin
    a_handover_start: assert property (leave_pack |->
        $past(t_switch) && $past(r.s2.rail_above_pack_185mv))
        else $error("hand-over started without delay or margin");
    a_dead_in: assert property ($rose(ctl.adapter_switch) |->
        off_run >= `PPCS_TMR_W'(`PPCS_DEAD_CYC))
        else $error("adapter switch on without dead time");
    // removal waits for sense level, then dead time
    a_drop_wait: assert property (leave_drop |-> $past(r.s2.sense_low_near_pack))
        else $error("return to pack before sense node fell");
    a_dead_out: assert property ($rose(ctl.pack_switch) && $past(pwr_on, 2) |->
        off_run >= `PPCS_TMR_W'(`PPCS_DEAD_CYC))
        else $error("pack switch on without dead time");
    a_slow_on: assert property ($rose(ctl.pack_switch) |-> ctl.pack_gate_slow)
        else $error("pack switch turned on fast");
    // request rises only after the full deglitch count
    a_deglitch: assert property ($rose(r.chg_req) |->
        r.dgl_cnt == `PPCS_DGL_W'(DEGLITCH_CYC))
        else $error("charge request before deglitch");
    a_learn_hold: assert property (learn_act |=>
        !ctl.adapter_switch && !ctl.charge_enable)
        else $error("adapter connected during learn");
    a_timer_restart: assert property (!adp_ok |=> r.det_cnt == '0)
        else $error("detection timer not restarted");
    a_default_target: assert property (r.s2.trim_at_supply |=>
        setpoint.voltage_target_mv == 16'($past(r.set.cell_count) * `PPCS_CELL_DEFAULT_MV))
        else $error("default target wrong");
    // limit never rises while input limiting acts
    a_limit_cut: assert property (ctl.dpm_active |->
        setpoint.charge_limit_code <= $past(setpoint.charge_limit_code))
        else $error("charge limit rose during input limiting");
    a_valid_rise: assert property (adp_ok && t_good |=> ctl.adapter_valid_out)
        else $error("adapter valid missing after delay");
    // battery feeds the system until hand-over
    a_pack_default: assert property (pwr_on && !adp_ok && r.sel == SEL_PACK |=>
        ctl.pack_switch && !ctl.adapter_switch)
        else $error("pack switch off without adapter");
    a_adapter_hold: assert property (pwr_on && r.sel == SEL_ADAPTER && !learn_act |=>
        ctl.adapter_switch && !ctl.pack_switch)
        else $error("adapter switch dropped while connected");
    a_adapter_slow: assert property ($rose(ctl.adapter_switch) |->
        ctl.adapter_gate_slow)
        else $error("adapter switch turned on fast");
    // low pack ends the learn override
    a_learn_exit: assert property (learn_act && r.s2.pack_below_2v9 |=> r.learn_exit)
        else $error("learn override kept with low pack");
endmodule // ppcs_sequencer
`default_nettype wire

/* ppcs_far_side.sv */
// far-side model: adapter source, selector switches and system sense node
`timescale 1ns/100ps
`default_nettype none
module ppcs_far_side
    import ppcs_pkg::*;
#(
    parameter int unsigned DECAY_CYC = 200
)(
    input  wire logic      clock,
    input  wire logic      adapter_plugged,
    input  wire ppcs_ctl_s ctl,
    output var  logic      sense_near_pack,
    output var  logic      rail_leads_pack,
    output var  logic      shoot_through
);
    int unsigned decay   = 0;
    logic        both_on = 1'b0;

    // a plugged adapter holds the rail well above the pack
    assign rail_leads_pack = adapter_plugged;

    // the load bleeds the system node slowly, so an early drop of the adapter switch shows
    always_ff @(posedge clock)
    begin
        if (adapter_plugged)
            decay <= 0;
        else if (decay < DECAY_CYC)
            decay <= decay + 1;
    end

    // node rests at the pack once nothing feeds it
    assign sense_near_pack = !adapter_plugged && (decay >= DECAY_CYC || !ctl.adapter_switch);

    // sticky record of both switches conducting together
    always_ff @(posedge clock)
    begin
        if (ctl.adapter_switch && ctl.pack_switch)
            both_on <= 1'b1;
    end
    assign shoot_through = both_on;
endmodule // ppcs_far_side
`default_nettype wire

/* ppcs_sequencer_tb.sv */
// self-checking bench of the power-path charge sequencer
`timescale 1ns/100ps
`default_nettype none
module ppcs_sequencer_tb;
    import ppcs_pkg::*;
    // short timers keep the run brief; dead time stays at its fixed length
    localparam int GOOD = 50, SWITCH = 70, CHARGE = 80, DGL = 20, DEAD = 1000, DECAY = 200;
    localparam int VOK = 6, ASW = 5, PSW = 4, CHG = 1;
    typedef struct packed {
        logic [3:0]  pins;
        logic [7:0]  code;
        logic [7:0]  cc;
        logic [2:0]  cells;
        logic [15:0] tgt;
    } ppcs_row_s;
    logic       clock     = 1'b0;
    logic       srst      = 1'b1;
    logic [7:0] trim      = 8'h00;
    logic [7:0] ccode     = 8'h00;
    logic       plugged   = 1'b0;
    int         bad_count = 0;
    int         cmp_count = 0;
    int         ncyc      = 0;
    int         t0;
    int         tp;
    int         flt [5]   = '{14, 11, 10, 9, 8};
    logic       near;
    logic       lead;
    logic       shoot;
    ppcs_comp_s host;
    ppcs_comp_s comp;
    ppcs_ctl_s  ctl;
    ppcs_set_s  setpoint;
    ppcs_row_s  rows [5];

    // clock and a cycle count for measuring delays
    always #5 clock = ~clock;
    always @(posedge clock) ncyc <= ncyc + 1;

    // the far side supplies the sense node, which depends on the adapter switch, and the rail-above-pack level
    always_comb
    begin
        comp = host;
        comp.sense_low_near_pack = near;
        comp.rail_above_pack_185mv = lead;
    end

    ppcs_sequencer #(.GOOD_CYC(GOOD), .SWITCH_CYC(SWITCH), .CHARGE_CYC(CHARGE),
        .DEGLITCH_CYC(DGL)) dut (.clock(clock), .srst(srst), .comp(comp),
        .voltage_trim_code(trim), .charge_current_code(ccode), .ctl(ctl),
        .setpoint(setpoint));
    ppcs_far_side #(.DECAY_CYC(DECAY)) far (.clock(clock), .adapter_plugged(plugged),
        .ctl(ctl), .sense_near_pack(near), .rail_leads_pack(lead), .shoot_through(shoot));

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait for one control bit to reach a level
    task automatic wait_bit(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (ctl[b] !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    // cycles since t0 must fall in lo..hi; outside, the count itself is reported
    task automatic span(input string what, input int lo, input int hi);
        int e;
        e = ncyc - t0;
        check(what, (e >= lo && e <= hi) ? lo : e, lo);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog well past the planned length of the run
    initial
    begin
        cyc(60000);
        bad_count++;
        $display("unexpected watchdog: expected end seen timeout");
        give_verdict();
    end

    // main sequence: table rows, then hand-written cases
    initial
    begin
        host = '0;
        host.rail_above_4v = 1'b1;
        host.rail_above_undervoltage_lockout = 1'b1;
        host.thermistor_in_window = 1'b1;
        host.ratio_ref_above_2v4 = 1'b1;
        host.charge_enable_n = 1'b1;
        rows = '{'{4'hA, 8'h00, 8'h40, 3'h2, 16'h20D0}, '{4'h1, 8'h00, 8'hFF, 3'h3, 16'h2EE0},
                 '{4'h4, 8'hFF, 8'h00, 3'h4, 16'h4678}, '{4'hD, 8'h80, 8'h01, 3'h4, 16'h4280},
                 '{4'h2, 8'h33, 8'h80, 3'h3, 16'h3138}};
        cyc(2);
        check("ctl in reset", ctl, 32'h0);
        check("setpoint in reset", setpoint, 32'h0);
        srst = 1'b0;
        foreach (rows[k])
        begin
            {host.cells_above_low, host.cells_above_high, host.trim_at_supply,
                host.detect_above_0v6} = rows[k].pins;
            trim = rows[k].code;
            ccode = rows[k].cc;
            cyc(300);
            check("cell_count", setpoint.cell_count, rows[k].cells); // cell decode
            check("target", setpoint.voltage_target_mv, rows[k].tgt); // target
            check("limit", setpoint.charge_limit_code, rows[k].cc); // limit ratio
            check("full bias", ctl.bias_full, rows[k].pins[0]); // full bias
            check("monitor", ctl.input_current_monitor, rows[k].pins[0]); // monitor
            check("selector", {ctl.pack_switch, ctl.adapter_switch}, 2'h2); // battery feeds
            if (!rows[k].pins[0])
                check("partial bias", ctl.bias_partial, 1'b1); // partial bias
            $display("test row %0d done", k);
        end
        host.rail_above_4v = 1'b0;
        cyc(8);
        check("ctl rail off", ctl, 32'h0); // all disabled
        host.rail_above_4v = 1'b1;
        $display("test rail off done");
        host.charge_enable_n = 1'b0;
        host.detect_above_0v6 = 1'b1;
        host.detect_above_2v4 = 1'b1;
        plugged = 1'b1;
        cyc(GOOD - 10);
        host.detect_above_2v4 = 1'b0;
        cyc(5);
        host.detect_above_2v4 = 1'b1;
        t0 = ncyc;
        cyc(GOOD - 5);
        check("early valid", ctl.adapter_valid_out, 1'b0); // timer restarts
        wait_bit(VOK, 1'b1, 20);
        span("valid delay", GOOD, GOOD + 8); // valid delay
        wait_bit(PSW, 1'b0, 40);
        span("hand-over start", SWITCH, SWITCH + 8); // hand-over delay
        tp = ncyc;
        check("adapter in break", ctl.adapter_switch, 1'b0); // break first
        wait_bit(CHG, 1'b1, 40);
        span("charge delay", CHARGE, CHARGE + 8); // charge delay
        check("gate supply", ctl.gate_drive_supply, 1'b1); // supply enabled
        t0 = tp;
        wait_bit(ASW, 1'b1, DEAD + 100);
        span("insert dead", DEAD, DEAD + 3); // dead time
        check("adapter slow on", ctl.adapter_gate_slow, 1'b1); // slow turn-on
        cyc(2100);
        check("connected", {ctl.adapter_gate_slow, ctl.pack_switch}, 2'h0);
        $display("test insertion done");
        host.charge_enable_n = 1'b1;
        cyc(8);
        check("charge off", {ctl.charge_enable, ctl.gate_drive_supply}, 2'h0);
        host.charge_enable_n = 1'b0;
        cyc(DGL / 2);
        host.charge_enable_n = 1'b1;
        cyc(DGL);
        check("glitch ignored", ctl.charge_enable, 1'b0); // short low
        host.charge_enable_n = 1'b0;
        t0 = ncyc;
        wait_bit(CHG, 1'b1, DGL + 20);
        span("deglitch", DGL + 1, DGL + 8); // deglitch span
        $display("test deglitch done");
        host.input_power_limiting = 1'b1;
        host.input_over_limit = 1'b1;
        cyc(300);
        check("limit cut", {ctl.dpm_active, setpoint.charge_limit_code}, 9'h100);
        host.input_over_limit = 1'b0;
        cyc(300);
        check("limit back", {ctl.dpm_active, setpoint.charge_limit_code}, {1'b0, ccode});
        $display("test input limit done");
        foreach (flt[k])
        begin
            host[flt[k]] = ~host[flt[k]];
            cyc(8);
            check("fault stops charge", ctl.charge_enable, 1'b0); // fault
            host[flt[k]] = ~host[flt[k]];
            wait_bit(CHG, 1'b1, CHARGE + DGL + 20);
            check("charge resumes", ctl.charge_enable, 1'b1); // resume
        end
        $display("test faults done");
        host.learn = 1'b1;
        cyc(8);
        check("learn", {ctl.adapter_switch, ctl.charge_enable}, 2'h0); // override
        wait_bit(PSW, 1'b1, DEAD + 20);
        check("learn pack on", ctl.pack_switch, 1'b1); // battery feeds
        host.pack_below_2v9 = 1'b1;
        cyc(8);
        check("learn exit", ctl.pack_switch, 1'b0); // pack off
        wait_bit(ASW, 1'b1, DEAD + 20);
        check("learn exit adapter", ctl.adapter_switch, 1'b1); // adapter on
        host.learn = 1'b0;
        host.pack_below_2v9 = 1'b0;
        cyc(20);
        $display("test learn done");
        host.detect_above_2v4 = 1'b0;
        host.detect_above_0v6 = 1'b0;
        plugged = 1'b0;
        t0 = ncyc;
        cyc(100);
        check("wait drop", {ctl.adapter_switch, ctl.adapter_valid_out, ctl.charge_enable},
            3'h4); // held
        wait_bit(ASW, 1'b0, 300);
        span("sense wait", DECAY, DECAY + 8); // sense wait
        t0 = ncyc;
        wait_bit(PSW, 1'b1, DEAD + 20);
        span("removal dead", DEAD, DEAD + 3); // dead time
        check("pack slow on", ctl.pack_gate_slow, 1'b1); // slow turn-on
        check("no adapter", {ctl.adapter_switch, ctl.input_current_monitor, ctl.bias_partial},
            3'h1); // idle state
        $display("test removal done");
        srst = 1'b1;
        cyc(1);
        check("ctl second reset", ctl, 32'h0);
        srst = 1'b0;
        cyc(2);
        check("ctl two edges after reset", ctl, 32'h0); // synchroniser latency
        check("shoot-through", shoot, 1'b0); // never both on
        give_verdict();
    end
endmodule // ppcs_sequencer_tb
`default_nettype wire
